// File: design/astoc_cfg.svh
// register offsets, field positions and timing figures of the status block
// assumes a 100 MHz core clock
`ifndef ASTOC_CFG_SVH
`define ASTOC_CFG_SVH
`define ASTOC_OFS_DATA 4'h0
`define ASTOC_OFS_ERR 4'h1
`define ASTOC_OFS_CTL 4'h6
`define ASTOC_OFS_STAT 4'h7
`define ASTOC_CTL_SRST 2
`define ASTOC_CTL_NIEN 1
`define ASTOC_ERR_ABT 2
`define ASTOC_CLK_HZ 100000000
`define ASTOC_CLK_MHZ 100
`define ASTOC_T_BSY_NS 400
`define ASTOC_T_RDY_S 31
`define ASTOC_T_CMD_S 30
`define ASTOC_T_SEC_S 10
`define ASTOC_T_DRQ_US 700
`define ASTOC_T_RDBSY_US 10
`define ASTOC_T_WRBSY_US 5
`define ASTOC_BSY_CYC (`ASTOC_T_BSY_NS * `ASTOC_CLK_MHZ / 1000)
`define ASTOC_RDBSY_CYC (`ASTOC_T_RDBSY_US * `ASTOC_CLK_MHZ)
`define ASTOC_WRBSY_CYC (`ASTOC_T_WRBSY_US * `ASTOC_CLK_MHZ)
`define ASTOC_WORDS 9'd256
`endif

// File: design/astoc_pkg.sv
// types shared by the status timing block and its surroundings
// no assumptions beyond a synthesizable SystemVerilog flow
package astoc_pkg;
  typedef enum logic [2:0] {
    CLS_NONE, CLS_PIO_IN, CLS_PIO_OUT, CLS_NODATA, CLS_DMA
  } astoc_cls_type;
  typedef enum logic [2:0] {
    ST_INIT, ST_SRST, ST_IDLE, ST_EXEC, ST_DRQ_IN, ST_DRQ_OUT
  } astoc_state_type;
  typedef struct packed {
    logic [7:0] opcode;
    astoc_cls_type cls;
  } astoc_cmd_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } astoc_bus_type;
endpackage : astoc_pkg

// File: design/astoc_core.sv
// ata host-port status sequencer: busy/ready/drq timing and opcode decode
// assumes a back end that signals readiness and supplies/takes 16-bit words
//
// Summary of operation
// - after power-on reset show busy at once, then ready within 31 s
// - soft reset bit sets busy at once; ready within 31 s after it clears
// - bus hardware reset sets busy at once; ready within 31 s after it is released
// - every command write accepted in idle sets busy within 400 ns
// - data-in: drop busy, raise drq and interrupt within 30 s
// - data-in: busy again within 10 us after 256th data read
// - data-out: drop busy and raise drq within 700 us
// - data-out: busy again within 5 us after 256th data write
// - data-out end: ready and interrupt within 30 s of last busy
// - non-data command: completion interrupt within 30 s of busy
// - a security command that is the first command after standby power-up gets a 10 s drq limit
// - decode implemented opcodes, 1xh recalibrate, 7xh seek, 3ch write
// - nop, device reset, packet, service, queued, cfa, 92h, 94h-99h unsupported
// - sector data moves as 256 sixteen-bit data register accesses
`timescale 1ns/1ps
`include "astoc_cfg.svh"
module astoc_core #(
  parameter logic [31:0] P_RDY_CYC = 32'(64'(`ASTOC_T_RDY_S) * 64'(`ASTOC_CLK_HZ)),
  parameter logic [31:0] P_CMD_CYC = 32'(64'(`ASTOC_T_CMD_S) * 64'(`ASTOC_CLK_HZ)),
  parameter logic [31:0] P_SEC_CYC = 32'(64'(`ASTOC_T_SEC_S) * 64'(`ASTOC_CLK_HZ)),
  parameter logic [31:0] P_DRQ_CYC = 32'(`ASTOC_T_DRQ_US * `ASTOC_CLK_MHZ)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire astoc_pkg::astoc_bus_type bus_i,
  output logic [15:0] rdata_o,
  input wire logic ata_reset_i,
  input wire logic standby_pwr_i,
  input wire logic init_done_i,
  input wire logic be_rdy_i,
  input wire logic be_last_i,
  input wire logic [15:0] be_word_i,
  output astoc_pkg::astoc_cmd_type cmd_o,
  output logic cmd_start_o,
  output logic word_pop_o,
  output logic word_push_o,
  output logic [15:0] word_o,
  output logic intrq_o
);
  import astoc_pkg::*;

  localparam int BSY_MAX = `ASTOC_BSY_CYC;
  localparam int RDBSY_MAX = `ASTOC_RDBSY_CYC;
  localparam int WRBSY_MAX = `ASTOC_WRBSY_CYC;

  function automatic astoc_cls_type decode(input logic [7:0] op);
    astoc_cls_type c;
    c = CLS_NONE;
    if (op[7:4] == 4'h1 || op[7:4] == 4'h7) begin
      c = CLS_NODATA;
    end else begin
      case (op)
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'hc4, 8'he4, 8'hec: c = CLS_PIO_IN;
        8'h30, 8'h31, 8'h32, 8'h33, 8'h3c, 8'h50, 8'hc5, 8'he8,
        8'hf1, 8'hf2, 8'hf4, 8'hf6: c = CLS_PIO_OUT;
        8'hc8, 8'hc9, 8'hca, 8'hcb: c = CLS_DMA;
        8'h40, 8'h41, 8'h90, 8'h91, 8'hb0, 8'hc6, 8'he0, 8'he1, 8'he2,
        8'he3, 8'he5, 8'he6, 8'he7, 8'hef, 8'hf0, 8'hf3, 8'hf5, 8'hf7,
        8'hf8, 8'hf9: c = CLS_NODATA;
        default: c = CLS_NONE;
      endcase
    end
    return c;
  endfunction : decode

  function automatic logic is_sec_pw(input logic [7:0] op);
    return (op == 8'hf1 || op == 8'hf2 || op == 8'hf4 || op == 8'hf6);
  endfunction : is_sec_pw

  ////////////////////////////////////////////////////////////////////////
  // control group
  astoc_state_type state_ff, nxt_state;
  astoc_cmd_type cmd_ff, nxt_cmd;
  logic bsy_ff, nxt_bsy, rdy_ff, nxt_rdy, drq_ff, nxt_drq;
  logic err_ff, nxt_err, abt_ff, nxt_abt, intrq_ff, nxt_intrq;
  logic srst_ff, nxt_srst, nien_ff, nxt_nien;
  logic first_ff, nxt_first, ext_ff, nxt_ext, last_ff, nxt_last;
  logic stby_ff, nxt_stby, strap_ff, nxt_strap, blk_ff, nxt_blk;
  logic [31:0] tmr_ff, nxt_tmr, lim_c;
  logic [8:0] cnt_ff, nxt_cnt;
  logic [15:0] word_ff, nxt_word;
  logic cmd_wr_c, ctl_wr_c, data_rd_c, data_wr_c, stat_rd_c, int_set_c;
  logic start_c, pop_c, push_c;

  assign cmd_wr_c = bus_i.wr && bus_i.addr == `ASTOC_OFS_STAT;
  assign ctl_wr_c = bus_i.wr && bus_i.addr == `ASTOC_OFS_CTL;
  assign data_rd_c = bus_i.rd && bus_i.addr == `ASTOC_OFS_DATA;
  assign data_wr_c = bus_i.wr && bus_i.addr == `ASTOC_OFS_DATA;
  assign stat_rd_c = bus_i.rd && bus_i.addr == `ASTOC_OFS_STAT;

  always_comb begin
    if (state_ff == ST_INIT) begin
      lim_c = P_RDY_CYC;
    end else if (cmd_ff.cls == CLS_PIO_OUT && !blk_ff) begin
      lim_c = ext_ff ? P_SEC_CYC : P_DRQ_CYC;
    end else begin
      lim_c = P_CMD_CYC;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_bsy = bsy_ff;
    nxt_rdy = rdy_ff;
    nxt_drq = drq_ff;
    nxt_err = err_ff;
    nxt_abt = abt_ff;
    nxt_srst = srst_ff;
    nxt_nien = nien_ff;
    nxt_first = first_ff;
    nxt_ext = ext_ff;
    nxt_last = last_ff;
    nxt_blk = blk_ff;
    nxt_tmr = tmr_ff;
    nxt_cnt = cnt_ff;
    nxt_word = word_ff;
    nxt_strap = 1'b1;
    nxt_stby = strap_ff ? stby_ff : standby_pwr_i;
    int_set_c = 1'b0;
    start_c = 1'b0;
    pop_c = 1'b0;
    push_c = 1'b0;
    if (ctl_wr_c) begin
      nxt_srst = bus_i.wdata[`ASTOC_CTL_SRST];
      nxt_nien = bus_i.wdata[`ASTOC_CTL_NIEN];
    end
    case (state_ff)
      ST_INIT: begin
        nxt_tmr = tmr_ff + 32'h1;
        // ready is forced at the limit so a stuck back end cannot hang the port
        if (init_done_i || tmr_ff >= lim_c - 32'h1) begin
          nxt_state = ST_IDLE;
          nxt_bsy = 1'b0;
          nxt_rdy = 1'b1;
        end
      end
      ST_SRST: begin
        nxt_tmr = 32'h0;
        if (!srst_ff) begin
          nxt_state = ST_INIT;
        end
      end
      ST_IDLE: begin
        // commands during busy or drq are ignored
        if (cmd_wr_c) begin
          nxt_cmd.opcode = bus_i.wdata[7:0];
          nxt_cmd.cls = decode(bus_i.wdata[7:0]);
          nxt_bsy = 1'b1;
          nxt_err = 1'b0;
          nxt_abt = 1'b0;
          nxt_first = 1'b0;
          nxt_blk = 1'b0;
          nxt_ext = stby_ff && first_ff && is_sec_pw(bus_i.wdata[7:0]);
          nxt_tmr = 32'h0;
          nxt_state = ST_EXEC;
          start_c = decode(bus_i.wdata[7:0]) != CLS_NONE;
        end
      end
      ST_EXEC: begin
        nxt_tmr = tmr_ff + 32'h1;
        nxt_cnt = 9'h0;
        if (cmd_ff.cls == CLS_NONE || tmr_ff >= lim_c - 32'h1) begin
          nxt_state = ST_IDLE;
          nxt_bsy = 1'b0;
          nxt_rdy = 1'b1;
          nxt_err = 1'b1;
          nxt_abt = 1'b1;
          int_set_c = 1'b1;
        end else if (be_rdy_i) begin
          nxt_last = be_last_i;
          nxt_tmr = 32'h0;
          case (cmd_ff.cls)
            CLS_PIO_IN: begin
              if (blk_ff && last_ff) begin
                nxt_state = ST_IDLE;
                nxt_bsy = 1'b0;
                nxt_rdy = 1'b1;
              end else begin
                nxt_state = ST_DRQ_IN;
                nxt_bsy = 1'b0;
                nxt_drq = 1'b1;
                int_set_c = 1'b1;
              end
            end
            CLS_PIO_OUT: begin
              if (blk_ff && last_ff) begin
                nxt_state = ST_IDLE;
                nxt_bsy = 1'b0;
                nxt_rdy = 1'b1;
                int_set_c = 1'b1;
              end else begin
                nxt_state = ST_DRQ_OUT;
                nxt_bsy = 1'b0;
                nxt_drq = 1'b1;
                int_set_c = blk_ff;
              end
            end
            default: begin
              nxt_state = ST_IDLE;
              nxt_bsy = 1'b0;
              nxt_rdy = 1'b1;
              int_set_c = 1'b1;
            end
          endcase
        end
      end
      ST_DRQ_IN: begin
        if (data_rd_c) begin
          pop_c = 1'b1;
          nxt_cnt = cnt_ff + 9'h1;
          if (cnt_ff == `ASTOC_WORDS - 9'h1) begin
            nxt_bsy = 1'b1;
            nxt_drq = 1'b0;
            nxt_blk = 1'b1;
            nxt_state = ST_EXEC;
          end
        end
      end
      ST_DRQ_OUT: begin
        if (data_wr_c) begin
          push_c = 1'b1;
          nxt_word = bus_i.wdata;
          nxt_cnt = cnt_ff + 9'h1;
          if (cnt_ff == `ASTOC_WORDS - 9'h1) begin
            nxt_bsy = 1'b1;
            nxt_drq = 1'b0;
            nxt_blk = 1'b1;
            nxt_state = ST_EXEC;
          end
        end
      end
      default: nxt_state = ST_INIT;
    endcase
    if (ctl_wr_c && bus_i.wdata[`ASTOC_CTL_SRST]) begin
      nxt_state = ST_SRST;
      nxt_bsy = 1'b1;
      nxt_rdy = 1'b0;
      nxt_drq = 1'b0;
    end
    if (ata_reset_i) begin
      nxt_state = ST_INIT;
      nxt_bsy = 1'b1;
      nxt_rdy = 1'b0;
      nxt_drq = 1'b0;
      nxt_err = 1'b0;
      nxt_abt = 1'b0;
      nxt_srst = 1'b0;
      nxt_nien = 1'b0;
      nxt_tmr = 32'h0;
    end
    // a new completion in the clearing cycle wins over the clear
    nxt_intrq = (intrq_ff && !stat_rd_c && !cmd_wr_c) || int_set_c;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_INIT;
      cmd_ff <= '{opcode: 8'h00, cls: CLS_NONE};
      bsy_ff <= 1'b1;
      rdy_ff <= 1'b0;
      drq_ff <= 1'b0;
      err_ff <= 1'b0;
      abt_ff <= 1'b0;
      intrq_ff <= 1'b0;
      srst_ff <= 1'b0;
      nien_ff <= 1'b0;
      first_ff <= 1'b1;
      ext_ff <= 1'b0;
      last_ff <= 1'b0;
      blk_ff <= 1'b0;
      stby_ff <= 1'b0;
      strap_ff <= 1'b0;
      tmr_ff <= 32'h0;
      cnt_ff <= 9'h0;
      word_ff <= 16'h0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      bsy_ff <= nxt_bsy;
      rdy_ff <= nxt_rdy;
      drq_ff <= nxt_drq;
      err_ff <= nxt_err;
      abt_ff <= nxt_abt;
      intrq_ff <= nxt_intrq;
      srst_ff <= nxt_srst;
      nien_ff <= nxt_nien;
      first_ff <= nxt_first;
      ext_ff <= nxt_ext;
      last_ff <= nxt_last;
      blk_ff <= nxt_blk;
      stby_ff <= nxt_stby;
      strap_ff <= nxt_strap;
      tmr_ff <= nxt_tmr;
      cnt_ff <= nxt_cnt;
      word_ff <= nxt_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port group
  logic [15:0] rdata_ff, nxt_rdata;
  logic [7:0] stat_c;

  assign stat_c = {bsy_ff, rdy_ff, 1'b0, rdy_ff, drq_ff, 2'b00, err_ff};

  always_comb begin
    nxt_rdata = 16'h0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `ASTOC_OFS_DATA: nxt_rdata = drq_ff && state_ff == ST_DRQ_IN ? be_word_i : 16'h0;
        `ASTOC_OFS_ERR: nxt_rdata = {13'h0, abt_ff, 2'b00};
        `ASTOC_OFS_CTL, `ASTOC_OFS_STAT: nxt_rdata = {8'h00, stat_c};
        default: nxt_rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 16'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign cmd_o = cmd_ff;
  assign cmd_start_o = start_c;
  assign word_pop_o = pop_c;
  assign word_push_o = push_c;
  assign word_o = word_ff;
  assign intrq_o = intrq_ff && !nien_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cmd_busy: assert property (state_ff == ST_IDLE && cmd_wr_c && !ata_reset_i
    |-> ##[1:BSY_MAX] bsy_ff) else $error("busy late after command");
  a_hard_busy: assert property ($rose(ata_reset_i)
    |-> ##[1:BSY_MAX] (bsy_ff && !rdy_ff)) else $error("busy late after reset");
  a_soft_busy: assert property (ctl_wr_c && bus_i.wdata[`ASTOC_CTL_SRST] && !ata_reset_i
    |=> bsy_ff && state_ff == ST_SRST) else $error("busy late after soft reset");
  a_init_ready: assert property (state_ff == ST_INIT && !ata_reset_i && !ctl_wr_c
    && (init_done_i || tmr_ff >= P_RDY_CYC - 32'h1)
    |=> !bsy_ff && rdy_ff) else $error("ready not shown");
  a_tmr_bound: assert property (state_ff == ST_EXEC |-> tmr_ff < lim_c)
    else $error("phase limit overrun");
  a_in_drq_int: assert property ($rose(drq_ff) && cmd_ff.cls == CLS_PIO_IN
    |-> !bsy_ff && intrq_ff) else $error("data-in drq without interrupt");
  a_in_rebusy: assert property (state_ff == ST_DRQ_IN && data_rd_c
    && cnt_ff == 9'd255 && !ata_reset_i && !ctl_wr_c
    |-> ##[1:RDBSY_MAX] bsy_ff) else $error("busy late after read block");
  a_out_rebusy: assert property (state_ff == ST_DRQ_OUT && data_wr_c
    && cnt_ff == 9'd255 && !ata_reset_i && !ctl_wr_c
    |-> ##[1:WRBSY_MAX] bsy_ff) else $error("busy late after write block");
  a_out_drq_lim: assert property (state_ff == ST_EXEC && cmd_ff.cls == CLS_PIO_OUT
    && !blk_ff && !ext_ff |-> tmr_ff < P_DRQ_CYC) else $error("drq limit");
  a_out_done_int: assert property (state_ff == ST_EXEC && cmd_ff.cls == CLS_PIO_OUT
    && blk_ff && last_ff && be_rdy_i && !ata_reset_i && !ctl_wr_c
    |=> rdy_ff && !bsy_ff && intrq_ff) else $error("data-out end");
  a_nodata_int: assert property (state_ff == ST_EXEC && cmd_ff.cls == CLS_NODATA
    && be_rdy_i && !ata_reset_i && !ctl_wr_c |=> intrq_ff && rdy_ff)
    else $error("non-data completion");
  a_ext_limit: assert property (state_ff == ST_EXEC && ext_ff && !blk_ff
    |-> lim_c == P_SEC_CYC) else $error("security limit");
  a_seek_dec: assert property (state_ff == ST_IDLE && cmd_wr_c && !ata_reset_i
    && !ctl_wr_c && bus_i.wdata[7:4] == 4'h7 |=> cmd_ff.cls == CLS_NODATA)
    else $error("seek decode");
  a_abort: assert property (state_ff == ST_IDLE && cmd_wr_c && !ata_reset_i
    && !ctl_wr_c && decode(bus_i.wdata[7:0]) == CLS_NONE
    |-> ##2 (err_ff && abt_ff && intrq_ff)) else $error("abort missing");
  a_word_cnt: assert property (drq_ff |-> cnt_ff < 9'd256)
    else $error("word count overrun");

  c_abort: cover property (abt_ff && intrq_ff);
  c_in_block: cover property (state_ff == ST_DRQ_IN ##1 state_ff == ST_EXEC);
  c_out_block: cover property (state_ff == ST_DRQ_OUT ##1 state_ff == ST_EXEC);
  c_ext_drq: cover property (ext_ff && state_ff == ST_DRQ_OUT);
endmodule : astoc_core

// File: tb/astoc_be_model.sv
// back-end partner: init done, block readiness and a read-word source
// assumes one-cycle pop/push strobes and one-cycle command start pulses
`timescale 1ns/1ps
module astoc_be_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] lat_i,
  input wire logic mute_i,
  input wire logic cmd_start_i,
  input wire logic word_pop_i,
  input wire logic word_push_i,
  output logic init_done_o,
  output logic be_rdy_o,
  output logic be_last_o,
  output logic [15:0] be_word_o
);
  logic [7:0] dly_ff;
  logic [8:0] wc_ff;
  logic [4:0] init_ff;
  // single-block commands only, so every block is the last one
  assign be_last_o = 1'b1;
  assign init_done_o = (init_ff == 5'h1f);
  assign be_word_o = 16'h5a00 ^ {7'h00, wc_ff};
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_ff <= 8'h00;
      wc_ff <= 9'h000;
      init_ff <= 5'h00;
      be_rdy_o <= 1'b0;
    end else begin
      be_rdy_o <= 1'b0;
      if (init_ff != 5'h1f) init_ff <= init_ff + 5'h01;
      if (word_pop_i || word_push_i) wc_ff <= wc_ff + 9'h001;
      // a sector ends after 256 word accesses
      if (cmd_start_i || ((word_pop_i || word_push_i) && wc_ff == 9'h0ff)) begin
        dly_ff <= lat_i;
        wc_ff <= 9'h000;
      end else if (dly_ff != 8'h00) begin
        dly_ff <= dly_ff - 8'h01;
        // mute models a stuck back end, used to force a device timeout
        be_rdy_o <= (dly_ff == 8'h01) && !mute_i;
      end
    end
  end
endmodule : astoc_be_model

// File: tb/test_ata_status_timing_and_opcode_cover.sv
// self-checking bench for the status sequencer with a back-end model
// assumes short timing parameters so whole commands finish quickly
`timescale 1ns/1ps
module test_ata_status_timing_and_opcode_cover;
  import astoc_pkg::*;
  logic clk_i;
  logic rst_i;
  logic ata_reset;
  logic mute;
  logic stby;
  logic [7:0] lat;
  astoc_bus_type bus;
  logic [15:0] rdata;
  logic [15:0] be_word;
  logic [15:0] word;
  logic init_done, be_rdy, be_last, cmd_start, pop, push, intrq;
  astoc_cmd_type cmd;
  int fails = 0;
  int check_count = 0;
  int starts = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////
  astoc_core #(.P_RDY_CYC(32'd200), .P_CMD_CYC(32'd200), .P_SEC_CYC(32'd100),
    .P_DRQ_CYC(32'd50)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata), .ata_reset_i(ata_reset), .standby_pwr_i(stby),
    .init_done_i(init_done), .be_rdy_i(be_rdy), .be_last_i(be_last),
    .be_word_i(be_word), .cmd_o(cmd), .cmd_start_o(cmd_start), .word_pop_o(pop),
    .word_push_o(push), .word_o(word), .intrq_o(intrq));
  astoc_be_model be_u (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mute_i(mute),
    .cmd_start_i(cmd_start), .word_pop_i(pop), .word_push_i(push),
    .init_done_o(init_done), .be_rdy_o(be_rdy), .be_last_o(be_last),
    .be_word_o(be_word));
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cmd_start === 1'b1) starts++;
    // whole run needs well under this many cycles
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // polls alternate status so a pending interrupt is not cleared
  task automatic wait_stat(input logic [15:0] m, input logic [15:0] v, input int n,
    output logic [15:0] d);
    for (int i = 0; i < n; i++) begin
      rd(4'h6, d);
      if ((d & m) === v) break;
    end
  endtask : wait_stat
  // looks only after an edge has settled, so a level cleared on that edge is not taken
  task automatic wait_irq(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      if (intrq === 1'b1) break;
    end
    chk({15'h0000, intrq}, 16'h0001);
  endtask : wait_irq
  task automatic issue(input logic [7:0] op, input astoc_cls_type c);
    logic [15:0] d;
    int s;
    s = starts;
    wr(4'h7, {8'h00, op});
    #1 chk({13'h0000, cmd.cls}, {13'h0000, c});
    chk(16'(starts - s), 16'h0001);
    rd(4'h7, d);
    chk(d & 16'h0080, 16'h0080);
  endtask : issue
  ////////////////////////////////////////////////////////////////////
  task automatic t_power;
    logic [15:0] d;
    rd(4'h7, d);
    chk(d & 16'h0080, 16'h0080);
    wait_stat(16'h00c0, 16'h0040, 100, d);
    chk(d & 16'h00c0, 16'h0040);
  endtask : t_power
  task automatic t_data_in;
    logic [15:0] d;
    issue(8'h20, CLS_PIO_IN);
    wait_irq(200);
    rd(4'h7, d);
    chk(d & 16'h0088, 16'h0008);
    for (int k = 0; k < 256; k++) begin
      rd(4'h0, d);
      chk(d, 16'h5a00 ^ 16'(k));
    end
    rd(4'h6, d);
    chk(d & 16'h0080, 16'h0080);
    wait_stat(16'h00c8, 16'h0040, 100, d);
    chk(d & 16'h00c8, 16'h0040);
  endtask : t_data_in
  task automatic t_data_out;
    logic [15:0] d;
    issue(8'h30, CLS_PIO_OUT);
    wait_stat(16'h0088, 16'h0008, 25, d);
    chk(d & 16'h0088, 16'h0008);
    for (int k = 0; k < 256; k++) wr(4'h0, 16'hc300 + 16'(k));
    #1 chk(word, 16'hc3ff);
    rd(4'h6, d);
    chk(d & 16'h0080, 16'h0080);
    wait_irq(200);
    rd(4'h7, d);
    chk(d & 16'h00c9, 16'h0040);
  endtask : t_data_out
  task automatic t_nodata;
    logic [7:0] ops [7] = '{8'h10, 8'h1f, 8'h70, 8'h7f, 8'h90, 8'h91, 8'hc6};
    logic [15:0] d;
    foreach (ops[i]) begin
      issue(ops[i], CLS_NODATA);
      wait_irq(200);
      rd(4'h7, d);
      chk(d & 16'h00c9, 16'h0040);
    end
    issue(8'hc8, CLS_DMA);
    wait_irq(200);
    issue(8'h3c, CLS_PIO_OUT);
    for (int k = 0; k < 256; k++) wr(4'h0, 16'h0000);
    wait_irq(200);
  endtask : t_nodata
  task automatic t_unsup;
    logic [7:0] ops [13] = '{8'h00, 8'h03, 8'h08, 8'h38, 8'h87, 8'h92, 8'h94,
      8'h99, 8'ha0, 8'ha1, 8'ha2, 8'hc0, 8'hc7};
    logic [15:0] d;
    int s;
    foreach (ops[i]) begin
      s = starts;
      wr(4'h7, {8'h00, ops[i]});
      wait_irq(10);
      chk(16'(starts - s), 16'h0000);
      rd(4'h7, d);
      chk(d & 16'h0081, 16'h0001);
      rd(4'h1, d);
      chk(d & 16'h0004, 16'h0004);
    end
  endtask : t_unsup
  // stuck back end: device times out with an abort, host soft resets and retries
  task automatic t_srst;
    logic [15:0] d;
    mute <= 1'b1;
    issue(8'h10, CLS_NODATA);
    wait_irq(220);
    rd(4'h7, d);
    chk(d & 16'h0001, 16'h0001);
    wr(4'h6, 16'h0004);
    rd(4'h6, d);
    chk(d & 16'h0080, 16'h0080);
    mute <= 1'b0;
    wr(4'h6, 16'h0000);
    wait_stat(16'h00c0, 16'h0040, 100, d);
    chk(d & 16'h00c0, 16'h0040);
    issue(8'h10, CLS_NODATA);
    wait_irq(200);
    rd(4'h7, d);
    chk(d & 16'h00c1, 16'h0040);
  endtask : t_srst
  // standby strap with a mid-run power-on reset: only the first security command
  // gets the long drq limit, a repeat of it times out on the normal one
  task automatic t_stby;
    logic [15:0] d;
    @(posedge clk_i);
    stby <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    lat <= 8'd80;
    wait_stat(16'h00c0, 16'h0040, 100, d);
    chk(d & 16'h00c0, 16'h0040);
    issue(8'hf1, CLS_PIO_OUT);
    wait_stat(16'h0089, 16'h0008, 60, d);
    chk(d & 16'h0089, 16'h0008);
    wr(4'h6, 16'h0004);
    wr(4'h6, 16'h0000);
    wait_stat(16'h00c0, 16'h0040, 100, d);
    issue(8'hf1, CLS_PIO_OUT);
    wait_irq(100);
    rd(4'h7, d);
    chk(d & 16'h0089, 16'h0001);
    lat <= 8'd20;
  endtask : t_stby
  task automatic t_hrst;
    logic [15:0] d;
    @(posedge clk_i);
    ata_reset <= 1'b1;
    // read while reset is held: the back end reports init done at once
    rd(4'h6, d);
    chk(d & 16'h00c0, 16'h0080);
    @(posedge clk_i);
    ata_reset <= 1'b0;
    wait_stat(16'h00c0, 16'h0040, 100, d);
    chk(d & 16'h00c0, 16'h0040);
  endtask : t_hrst
  ////////////////////////////////////////////////////////////////////
  initial begin
    bus = '0;
    ata_reset = 1'b0;
    mute = 1'b0;
    stby = 1'b0;
    lat = 8'd20;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_data_in();
    t_data_out();
    lat <= 8'd1;
    t_nodata();
    lat <= 8'd20;
    t_unsup();
    t_srst();
    t_stby();
    t_hrst();
    end_sim();
  end
endmodule : test_ata_status_timing_and_opcode_cover
